// >>> apcs_pkg.sv
// Purpose: Shared constants for the converter control sequencer
// Assumes: System clock of 125 MHz
// Notes:   Counts are in conversion clock ticks unless named _CYC
// ============================================================
// Package
package apcs_pkg;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned CTRL_W         = 6;
  // Bus index field and register indices
  localparam int unsigned IDX_HI         = 7;
  localparam int unsigned IDX_LO         = 6;
  localparam logic [1:0]  IDX_CONV       = 2'h0;
  localparam logic [1:0]  IDX_FMT        = 2'h1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  // Conversion control fields
  localparam int unsigned BIT_START      = 5;
  localparam int unsigned BIT_STYLE      = 4;
  localparam int unsigned BIT_CLOCK_SOURCE_SELECT     = 3;
  localparam int unsigned BIT_SWPD       = 2;
  // Format control fields
  localparam int unsigned BIT_TWOS       = 1;
  localparam int unsigned BIT_FAST       = 4;
  // Conversion timing in conversion clock ticks
  localparam int unsigned TOTAL_TICKS    = 16;
  localparam int unsigned SAMPLE_TICKS   = 6;
  localparam int unsigned CONV_TICKS     = TOTAL_TICKS - SAMPLE_TICKS;
  localparam int unsigned APD_MIN_TICKS  = 1;
  localparam int unsigned APD_WAKE_TICKS = 1;
  localparam int unsigned CPD_MIN_TICKS  = 2;
  localparam int unsigned CPD_WAKE_TICKS = 2;
  // Oscillator emulation
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned OSC_SLOW_NS    = 100;
  localparam int unsigned OSC_FAST_NS    = 50;
  localparam int unsigned OSC_SLOW_CYC   = OSC_SLOW_NS / CLK_PERIOD_NS;
  localparam int unsigned OSC_FAST_CYC   = OSC_FAST_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  TICK_CNT_ZERO  = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WAKE    = 3'b001,
    ST_SAMPLE  = 3'b010,
    ST_CONVERT = 3'b011,
    ST_DONE    = 3'b100,
    ST_AUTO_PD = 3'b101,
    ST_CS_PD   = 3'b110
  } apcs_state_e;
endpackage : apcs_pkg

// >>> apcs_tick_gen.sv
// Purpose: Conversion clock tick from gated oscillator or external clock
// Assumes: ext_clk_s_i already synchronised to clk_i
// Notes:   Oscillator divider restarts from zero when run_i rises
`timescale 1ns/1ns
`default_nettype none
module apcs_tick_gen
  import apcs_pkg::*;
#(
  parameter int unsigned SLOW_DIV = OSC_SLOW_CYC,
  parameter int unsigned FAST_DIV = OSC_FAST_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ext_sel_i,
  input  wire logic fast_i,
  input  wire logic run_i,
  input  wire logic ext_clk_s_i,
  output logic      tick_o
);
  initial begin
    if (SLOW_DIV < 2 || SLOW_DIV > 16 || FAST_DIV < 2 || FAST_DIV > 16) begin
      $error("apcs_tick_gen: divider out of range");
    end
  end

  logic [3:0] div_ff, nxt_div;
  logic       ext_q_ff;
  logic [3:0] div_last;
  logic       osc_tick;

  assign div_last = fast_i ? 4'(FAST_DIV - 1) : 4'(SLOW_DIV - 1);
  assign osc_tick = run_i && (div_ff == div_last);
  // External clock is always the reference when selected
  assign tick_o   = ext_sel_i ? (ext_clk_s_i && !ext_q_ff) : osc_tick;

  always_comb begin
    nxt_div = div_ff;
    if (!run_i || osc_tick) begin
      nxt_div = TICK_CNT_ZERO;
    end else begin
      nxt_div = div_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff   <= TICK_CNT_ZERO;
      ext_q_ff <= 1'b0;
    end else begin
      div_ff   <= nxt_div;
      ext_q_ff <= ext_clk_s_i;
    end
  end
endmodule : apcs_tick_gen
`default_nettype wire

// >>> apcs_top.sv
// Purpose: Control and sequencing of an 8-bit parallel-port converter
// Assumes: Pins asynchronous to clk_i; code from SAR core on conv_code_i
// Notes:   Bus drive is split into data_o and data_oe_o
`timescale 1ns/1ns
`default_nettype none
module apcs_top
  import apcs_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic              cs_n_i,
  input  wire logic              wr_n_i,
  input  wire logic              rd_n_i,
  input  wire logic              hw_convert_trigger_n_i,
  input  wire logic              ext_clk_i,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic [DATA_W-1:0] conv_code_i,
  output logic      [DATA_W-1:0] data_o,
  output logic                   data_oe_o,
  output logic                   eoc_n_o,
  output logic                   sampling_o,
  output logic                   converting_o,
  output logic                   comparator_en_o,
  output logic                   clk_buffer_en_o,
  output logic                   auto_power_down_o,
  output logic                   deep_power_down_o
);
  // ============================================================
  // Reset and pin synchronisers
  logic [1:0] rst_sync_ff;
  logic       rst_n;
  logic [4:0] pin_a_ff, pin_b_ff, pin_q_ff;
  logic [DATA_W-1:0] dat_a_ff, dat_s_ff;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      // Select resets low so a reset cannot fake a deselect power down
      pin_a_ff <= 5'h0e;
      pin_b_ff <= 5'h0e;
      pin_q_ff <= 5'h0e;
      dat_a_ff <= 8'h00;
      dat_s_ff <= 8'h00;
    end else begin
      pin_a_ff <= {ext_clk_i, hw_convert_trigger_n_i, rd_n_i, wr_n_i, cs_n_i};
      pin_b_ff <= pin_a_ff;
      pin_q_ff <= pin_b_ff;
      dat_a_ff <= data_i;
      dat_s_ff <= dat_a_ff;
    end
  end

  logic cs_s, wr_s, rd_s, trg_s, ext_s;
  logic wr_rise, rd_fall, rd_rise, trg_fall;
  assign {ext_s, trg_s, rd_s, wr_s, cs_s} = pin_b_ff;
  assign wr_rise  = wr_s && !pin_q_ff[1];
  assign rd_fall  = !rd_s && pin_q_ff[2];
  assign rd_rise  = rd_s && !pin_q_ff[2];
  assign trg_fall = !trg_s && pin_q_ff[3];

  // ============================================================
  // Control registers
  logic [CTRL_W-1:0] conv_ctrl_ff, nxt_conv_ctrl;
  logic [CTRL_W-1:0] fmt_ctrl_ff, nxt_fmt_ctrl;
  logic [DATA_W-1:0] wdat_ff, nxt_wdat;
  logic              hw_cfg_ff, nxt_hw_cfg;
  logic              wr_commit, dummy_rd, start_eff;

  assign wr_commit = wr_rise && !cs_s;
  assign dummy_rd  = rd_fall && !wr_s && !cs_s;

  always_comb begin
    nxt_conv_ctrl = conv_ctrl_ff;
    nxt_fmt_ctrl  = fmt_ctrl_ff;
    nxt_hw_cfg    = hw_cfg_ff;
    nxt_wdat      = wdat_ff;
    // Bus data held on the last cycle the strobe is low
    if (!wr_s && !cs_s && !hw_cfg_ff) begin
      nxt_wdat = dat_s_ff;
    end
    if (dummy_rd) begin
      nxt_conv_ctrl = CTRL_RST;
      nxt_fmt_ctrl  = CTRL_RST;
      nxt_hw_cfg    = 1'b1;
    end else if (wr_commit) begin
      nxt_hw_cfg = 1'b0;
      if (!hw_cfg_ff) begin
        case (wdat_ff[IDX_HI:IDX_LO])
          IDX_CONV: nxt_conv_ctrl = wdat_ff[CTRL_W-1:0];
          IDX_FMT:  nxt_fmt_ctrl  = wdat_ff[CTRL_W-1:0];
          default:  nxt_conv_ctrl = conv_ctrl_ff;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      conv_ctrl_ff <= CTRL_RST;
      fmt_ctrl_ff  <= CTRL_RST;
      wdat_ff      <= 8'h00;
      hw_cfg_ff    <= 1'b0;
    end else begin
      conv_ctrl_ff <= nxt_conv_ctrl;
      fmt_ctrl_ff  <= nxt_fmt_ctrl;
      wdat_ff      <= nxt_wdat;
      hw_cfg_ff    <= nxt_hw_cfg;
    end
  end

  logic sw_start, level_style, ext_sel, soft_pd;
  assign sw_start    = conv_ctrl_ff[BIT_START];
  assign level_style = conv_ctrl_ff[BIT_STYLE];
  assign ext_sel     = conv_ctrl_ff[BIT_CLOCK_SOURCE_SELECT];
  assign soft_pd     = conv_ctrl_ff[BIT_SWPD];
  // Software start of the write that sets the start bit itself
  assign start_eff = (wr_commit && wdat_ff[IDX_HI:IDX_LO] == IDX_CONV)
                     ? wdat_ff[BIT_START] : sw_start;

  // ============================================================
  // Conversion clock
  logic tick, osc_run;
  apcs_tick_gen u_tick (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .ext_sel_i   (ext_sel),
    .fast_i      (fmt_ctrl_ff[BIT_FAST]),
    .run_i       (osc_run),
    .ext_clk_s_i (ext_s),
    .tick_o      (tick)
  );

  // ============================================================
  // Sequencer
  apcs_state_e state_ff, nxt_state;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic [3:0]  wake_ff, nxt_wake;
  logic [DATA_W-1:0] result_ff, nxt_result;
  logic        trigger;

  assign trigger = !cs_s && (start_eff
                   ? ((wr_commit && !hw_cfg_ff) || rd_rise)
                   : trg_fall);
  // Oscillator runs in every state except ST_IDLE and ST_AUTO_PD
  assign osc_run = (state_ff != ST_IDLE) &&
                   (state_ff != ST_AUTO_PD);

  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_wake   = wake_ff;
    nxt_result = result_ff;
    if (cs_s && state_ff != ST_CS_PD) begin
      nxt_state = ST_CS_PD;
      nxt_cnt   = TICK_CNT_ZERO;
    end else begin
      case (state_ff)
        ST_IDLE, ST_DONE: begin
          if (trigger) begin
            nxt_state = ST_SAMPLE;
            nxt_cnt   = TICK_CNT_ZERO;
          end else if (state_ff == ST_DONE && rd_fall) begin
            nxt_state = ST_IDLE;
          end else if (state_ff == ST_DONE && tick) begin
            nxt_state = ST_AUTO_PD;
            nxt_cnt   = TICK_CNT_ZERO;
          end
        end
        ST_AUTO_PD: begin
          if (trigger) begin
            nxt_state = ST_WAKE;
            nxt_cnt   = TICK_CNT_ZERO;
            nxt_wake  = 4'(APD_WAKE_TICKS);
          end
        end
        ST_CS_PD: begin
          if (tick && cnt_ff < 4'(CPD_MIN_TICKS)) begin
            nxt_cnt = cnt_ff + 4'h1;
          end
          if (!cs_s && cnt_ff >= 4'(CPD_MIN_TICKS)) begin
            nxt_state = ST_WAKE;
            nxt_cnt   = TICK_CNT_ZERO;
            nxt_wake  = 4'(CPD_WAKE_TICKS);
          end
        end
        ST_WAKE: begin
          if (tick) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == wake_ff - 4'h1) begin
              nxt_cnt   = TICK_CNT_ZERO;
              nxt_state = (wake_ff == 4'(CPD_WAKE_TICKS))
                          ? ST_IDLE : ST_SAMPLE;
            end
          end
        end
        ST_SAMPLE: begin
          if (!sw_start) begin
            if (trg_s) begin
              nxt_state = ST_CONVERT;
              nxt_cnt   = TICK_CNT_ZERO;
            end
          end else if (tick) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == 4'(SAMPLE_TICKS - 1)) begin
              nxt_state = ST_CONVERT;
              nxt_cnt   = TICK_CNT_ZERO;
            end
          end
        end
        ST_CONVERT: begin
          if (tick) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == 4'(CONV_TICKS - 1)) begin
              nxt_state  = ST_DONE;
              nxt_cnt    = TICK_CNT_ZERO;
              nxt_result = conv_code_i;
            end
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_cnt   = TICK_CNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= TICK_CNT_ZERO;
      wake_ff   <= TICK_CNT_ZERO;
      result_ff <= 8'h00;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      wake_ff   <= nxt_wake;
      result_ff <= nxt_result;
    end
  end

  // ============================================================
  // Host read port and status outputs
  logic [DATA_W-1:0] dout_ff, nxt_dout;
  logic              oe_ff, nxt_oe, eoc_n_ff, nxt_eoc_n;

  always_comb begin
    nxt_dout = dout_ff;
    nxt_oe   = oe_ff && !rd_s && !cs_s;
    if (rd_fall && !cs_s && wr_s) begin
      nxt_oe   = 1'b1;
      nxt_dout = fmt_ctrl_ff[BIT_TWOS]
                 ? {~result_ff[DATA_W-1], result_ff[DATA_W-2:0]}
                 : result_ff;
    end
    if (level_style) begin
      nxt_eoc_n = (nxt_state != ST_CONVERT);
    end else begin
      nxt_eoc_n = (nxt_state != ST_DONE);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dout_ff  <= 8'h00;
      oe_ff    <= 1'b0;
      eoc_n_ff <= 1'b1;
    end else begin
      dout_ff  <= nxt_dout;
      oe_ff    <= nxt_oe;
      eoc_n_ff <= nxt_eoc_n;
    end
  end

  assign data_o            = dout_ff;
  assign data_oe_o         = oe_ff;
  assign eoc_n_o           = eoc_n_ff;
  assign sampling_o        = (state_ff == ST_SAMPLE);
  assign converting_o      = (state_ff == ST_CONVERT);
  assign auto_power_down_o = (state_ff == ST_AUTO_PD);
  assign deep_power_down_o = (state_ff == ST_CS_PD) || soft_pd;
  assign comparator_en_o   = !auto_power_down_o && !deep_power_down_o;
  assign clk_buffer_en_o   = comparator_en_o;

  // ============================================================
  // Assertions
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_conv_last;
    converting_o && tick && cnt_ff == 4'(CONV_TICKS - 1);
  endsequence
  sequence s_swsamp_last;
    sampling_o && sw_start && tick && cnt_ff == 4'(SAMPLE_TICKS - 1);
  endsequence

  a_conv_ten_end: assert property (s_conv_last ##0 !cs_s
    |=> state_ff == ST_DONE && result_ff == $past(conv_code_i))
    else $error("conversion did not end after ten ticks");
  a_conv_no_early: assert property (converting_o && tick
    && cnt_ff < 4'(CONV_TICKS - 1) && !cs_s |=> converting_o)
    else $error("conversion ended early");
  a_samp_six: assert property (s_swsamp_last ##0 !cs_s |=> converting_o)
    else $error("software sampling not six ticks");
  a_hw_samp_hold: assert property (sampling_o && !sw_start && !trg_s
    && !cs_s |=> sampling_o)
    else $error("hardware sampling ended with trigger low");
  a_pulse_eoc: assert property (!level_style && $past(!level_style)
    |-> eoc_n_o == (state_ff != ST_DONE))
    else $error("pulse completion mismatch");
  a_level_eoc: assert property (level_style && $past(level_style)
    |-> eoc_n_o == !converting_o)
    else $error("level completion mismatch");
  a_bus_release: assert property (data_oe_o |-> $past(!cs_s && !rd_s))
    else $error("bus driven outside read");
  a_cs_pd_enter: assert property (cs_s |=> state_ff == ST_CS_PD)
    else $error("select high did not power down");
  a_auto_pd: assert property (state_ff == ST_DONE && tick && !trigger
    && !rd_fall && !cs_s |=> auto_power_down_o)
    else $error("auto power down missed");
  a_osc_stop: assert property ((auto_power_down_o || state_ff == ST_IDLE)
    && !ext_sel |-> !tick)
    else $error("oscillator running while idle");
  a_cfg_whole: assert property (wr_commit && !hw_cfg_ff && !dummy_rd
    && wdat_ff[IDX_HI:IDX_LO] == IDX_CONV
    |=> conv_ctrl_ff == $past(wdat_ff[CTRL_W-1:0]))
    else $error("control write not whole");
  a_dummy_zero: assert property (dummy_rd
    |=> conv_ctrl_ff == CTRL_RST && fmt_ctrl_ff == CTRL_RST)
    else $error("dummy read did not load defaults");
endmodule : apcs_top
`default_nettype wire

// >>> apcs_host_model.sv
// Purpose: Host side of the parallel port: strobes, bus and clock pins
// Assumes: Strobes move just after clk_i rising edges
// Notes:   A released bus shows the inverse of its last level
`timescale 1ns/1ns
`default_nettype none
module apcs_host_model
  import apcs_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic [DATA_W-1:0] data_o,
  input  wire logic              data_oe_o,
  output logic                   cs_n_o,
  output logic                   wr_n_o,
  output logic                   rd_n_o,
  output logic                   trig_n_o,
  output logic                   ext_clk_o,
  output logic      [DATA_W-1:0] bus_o,
  output logic                   tmo_o
);
  // ==========================================================
  // Bus wire
  logic              drv;
  logic [DATA_W-1:0] val;
  logic [DATA_W-1:0] last;
  assign bus_o = data_oe_o ? data_o : (drv ? val : ~last);
  always @(posedge clk_i) last <= bus_o;
  initial begin
    cs_n_o   = 1'b0;
    wr_n_o   = 1'b1;
    rd_n_o   = 1'b1;
    trig_n_o = 1'b1;
    drv      = 1'b0;
    val      = 8'h00;
    last     = 8'h00;
    tmo_o    = 1'b0;
  end
  // Free running, phase unrelated to clk_i, 8 clk_i periods
  initial begin
    ext_clk_o = 1'b0;
    #3;
    forever #32 ext_clk_o = ~ext_clk_o;
  end
  // ==========================================================
  // Pin cycles
  task automatic wr(input logic [DATA_W-1:0] b);
    @(posedge clk_i);
    drv    <= 1'b1;
    val    <= b;
    wr_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    drv    <= 1'b0;
  endtask : wr
  task automatic rd(output logic [DATA_W-1:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    rd_n_o <= 1'b0;
    @(posedge clk_i);
    while (data_oe_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) tmo_o <= 1'b1;
    v = bus_o;
    rd_n_o <= 1'b1;
    n = 0;
    @(posedge clk_i);
    while (data_oe_o !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) tmo_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : rd
  // Read strobe while the write strobe stays low; bus data offered too
  task automatic dummy(input logic [DATA_W-1:0] b);
    @(posedge clk_i);
    drv    <= 1'b1;
    val    <= b;
    wr_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    drv    <= 1'b0;
  endtask : dummy
  task automatic trig(input int lo);
    @(posedge clk_i);
    trig_n_o <= 1'b0;
    repeat (lo) @(posedge clk_i);
    trig_n_o <= 1'b1;
  endtask : trig
  task automatic sel(input logic v);
    @(posedge clk_i);
    cs_n_o <= v;
  endtask : sel
endmodule : apcs_host_model
`default_nettype wire

// >>> testbench.sv
// Purpose: Self-checking bench for the converter control sequencer
// Assumes: External conversion clock of 8 clk_i periods
// Notes:   Phase lengths are checked to one conversion tick
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import apcs_pkg::*;
  localparam int P  = 8;
  localparam int IP = 12;
  logic              clk_i;
  logic              resetn_i;
  logic              cs_n;
  logic              wr_n;
  logic              rd_n;
  logic              trig_n;
  logic              ext_clk;
  logic              tmo;
  logic [DATA_W-1:0] bus;
  logic [DATA_W-1:0] code;
  logic [DATA_W-1:0] got;
  logic [DATA_W-1:0] data_o;
  logic              oe;
  logic              eoc_n;
  logic              samp;
  logic              conv;
  logic              cmp_en;
  logic              clkb_en;
  logic              apd;
  logic              dpd;
  logic              eoc_q;
  int miscompares, check_count, cyc, samp_n, conv_n, eoc_lo, eoc_up, pd_n;
  int s0, c0, l0, e0, p0;
  apcs_top apcs_top_i (
    .clk_i                 (clk_i),
    .resetn_i              (resetn_i),
    .cs_n_i                (cs_n),
    .wr_n_i                (wr_n),
    .rd_n_i                (rd_n),
    .hw_convert_trigger_n_i(trig_n),
    .ext_clk_i             (ext_clk),
    .data_i                (bus),
    .conv_code_i           (code),
    .data_o                (data_o),
    .data_oe_o             (oe),
    .eoc_n_o               (eoc_n),
    .sampling_o            (samp),
    .converting_o          (conv),
    .comparator_en_o       (cmp_en),
    .clk_buffer_en_o       (clkb_en),
    .auto_power_down_o     (apd),
    .deep_power_down_o     (dpd)
  );
  apcs_host_model apcs_host_model_i (
    .clk_i    (clk_i),
    .data_o   (data_o),
    .data_oe_o(oe),
    .cs_n_o   (cs_n),
    .wr_n_o   (wr_n),
    .rd_n_o   (rd_n),
    .trig_n_o (trig_n),
    .ext_clk_o(ext_clk),
    .bus_o    (bus),
    .tmo_o    (tmo)
  );
  // ==========================================================
  // Clock, phase counters and hang limit
  initial clk_i = 1'b0;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc    <= cyc + 1;
    eoc_q  <= eoc_n;
    samp_n <= samp_n + int'(samp === 1'b1);
    conv_n <= conv_n + int'(conv === 1'b1);
    eoc_lo <= eoc_lo + int'(eoc_n === 1'b0);
    eoc_up <= eoc_up + int'(eoc_n === 1'b1 && eoc_q === 1'b0);
    pd_n   <= pd_n + int'(dpd === 1'b1 && !cmp_en && !clkb_en);
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end
  // ==========================================================
  // Checks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count = check_count + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %0t ns got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic near(input int g, input int e, input int t);
    chk(16'(((g > e - t) && (g < e + t)) ? e : g), 16'(e));
  endtask : near
  task automatic snap();
    s0 = samp_n;
    c0 = conv_n;
    l0 = eoc_lo;
    e0 = eoc_up;
    p0 = pd_n;
  endtask : snap
  task automatic wait_done();
    int n;
    n = 0;
    while (eoc_up == e0 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    chk(16'(n < 400), 16'h1);
  endtask : wait_done
  task automatic wait_apd();
    int n;
    n = 0;
    while (apd !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    chk(16'(cmp_en), 16'h0);
  endtask : wait_apd
  task automatic rd_chk(input logic [DATA_W-1:0] e);
    snap();
    apcs_host_model_i.rd(got);
    chk(16'(got), 16'(e));
    chk(16'(oe), 16'h0);
  endtask : rd_chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // Tests
  initial begin
    resetn_i = 1'b0;
    code = 8'hc3;
    repeat (6) @(posedge clk_i);
    chk(16'(oe), 16'h0);
    chk(16'(eoc_n), 16'h1);
    resetn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    apcs_host_model_i.wr(8'h08);
    snap();
    apcs_host_model_i.trig(40);
    wait_done();
    near(samp_n - s0, 40, P);
    near(conv_n - c0, 10 * P, P);
    near(eoc_lo - l0, P, 2);
    chk(16'(eoc_up - e0), 16'h1);
    wait_apd();
    rd_chk(code);
    $display("hardware start test done");
    code <= 8'h3c;
    snap();
    apcs_host_model_i.wr(8'h38);
    wait_done();
    near(samp_n - s0, 6 * P, P);
    near(conv_n - c0, 10 * P, P);
    near(samp_n - s0 + conv_n - c0, 16 * P, P);
    near(eoc_lo - l0, conv_n - c0, 2);
    apcs_host_model_i.wr(8'h42);
    rd_chk(code ^ 8'h80);
    wait_done();
    near(samp_n - s0, 6 * P, P);
    $display("software start test done");
    for (int i = 2; i < 4; i++) begin
      apcs_host_model_i.wr({i[1:0], 6'h00});
      rd_chk(code ^ 8'h80);
      wait_done();
    end
    $display("index decode test done");
    snap();
    apcs_host_model_i.sel(1'b1);
    repeat (4) @(posedge clk_i);
    apcs_host_model_i.sel(1'b0);
    repeat (8 * P) @(posedge clk_i);
    chk(16'(pd_n - p0 > P), 16'h1);
    chk(16'(cmp_en), 16'h1);
    rd_chk(code ^ 8'h80);
    wait_done();
    apcs_host_model_i.wr(8'h40);
    rd_chk(code);
    wait_done();
    snap();
    apcs_host_model_i.wr(8'h3c);
    chk(16'(dpd), 16'h1);
    chk(16'(cmp_en), 16'h0);
    wait_done();
    $display("power down test done");
    apcs_host_model_i.dummy(8'h42);
    chk(16'(dpd), 16'h0);
    code <= 8'h81;
    snap();
    apcs_host_model_i.trig(24);
    wait_done();
    near(conv_n - c0, 10 * IP, IP);
    wait_apd();
    rd_chk(code);
    chk(16'(tmo), 16'h0);
    $display("default load test done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
